// >>> osd_cfg.svh
// Purpose: offsets, field positions, reset values and counts for the
//          on-screen-display host port and its software-side controller
// Assumes: byte-wide host ports, one clock domain
// Notes:   definitions only
`ifndef OSD_CFG_SVH
`define OSD_CFG_SVH

// host i/o port map
`define OSD_PORT_INDEX 8'ha0
`define OSD_PORT_DATA 8'ha1
`define OSD_PORT_PTR_LO 8'ha2
`define OSD_PORT_PTR_HI 8'ha3
`define OSD_PORT_RAM_DATA 8'ha4

// configuration space behind the index/data pair
`define OSD_CFG_COUNT 16
`define OSD_LUT_DATA_INDEX 8'h0e
`define OSD_FONT_SIZE_INDEX 4'hd
`define OSD_CODING_INDEX 4'hf
`define OSD_CODING_MODE_LSB 2
`define OSD_FONT_WIDTH_LSB 0
`define OSD_INDEX_RESET 8'h00
`define OSD_CFG_RESET 8'h00

// colour table
`define OSD_LUT_ENTRIES 16
`define OSD_LUT_PTR_IDLE 4'h1

// display ram
`define OSD_RAM_WORDS 1024
`define OSD_PTR_RESET 12'h000

// software-side controller registers (apb byte addresses)
`define HOST_REG_CMD 12'h000
`define HOST_REG_STATUS 12'h004
`define HOST_CMD_DATA_LSB 0
`define HOST_CMD_PORT_LSB 8
`define HOST_CMD_WRITE_BIT 16
`define HOST_STAT_BUSY_BIT 0
`define HOST_STAT_RDATA_LSB 8

`endif

// >>> osd_colour_map.sv
// Purpose: decode foreground/background/bitmap codes into table entries
// Assumes: purely combinational, registered by the caller
// Notes:   entry index is meaningless while the transparent flag is high
`default_nettype none
module osd_colour_map
  import osd_pkg::*;
(
  input wire logic [1:0] coding_mode_i,
  input wire logic bitmap_i,
  input wire logic two_bpp_i,
  input wire logic [3:0] foreground_code_i,
  input wire logic [2:0] background_code_i,
  input wire logic [3:0] row_foreground_colour_i,
  input wire logic [2:0] row_background_colour_i,
  input wire logic [1:0] pixel_i,
  output logic [3:0] fg_entry_o,
  output logic fg_clear_o,
  output logic [3:0] bg_entry_o,
  output logic bg_clear_o
);

  // background codes land on even table entries only
  function automatic logic [3:0] even_entry(input logic [2:0] code);
    even_entry = {code, 1'b0};
  endfunction : even_entry

  always_comb begin
    fg_entry_o = 4'h0;
    bg_entry_o = 4'h0;
    if (bitmap_i) begin
      if (two_bpp_i) begin
        fg_entry_o = {2'b00, pixel_i}; // [R06]
      end else begin
        fg_entry_o = {3'b000, pixel_i[0]}; // [R05]
      end
    end else begin
      case (coding_mode_e'(coding_mode_i))
        MODE_FULL: begin
          fg_entry_o = foreground_code_i; // [R01]
          bg_entry_o = even_entry(background_code_i); // [R02]
        end
        MODE_ROW_ATTR: begin
          fg_entry_o = foreground_code_i[0] ?
                       row_foreground_colour_i : 4'h0; // [R03]
          bg_entry_o = background_code_i[0] ?
                       even_entry(row_background_colour_i) : 4'h0; // [R03]
        end
        MODE_NARROW: begin
          fg_entry_o = {2'b00, foreground_code_i[1:0]}; // [R04]
          bg_entry_o = background_code_i[0] ?
                       even_entry(row_background_colour_i) : 4'h0; // [R04]
        end
        default: begin
          fg_entry_o = 4'h0;
          bg_entry_o = 4'h0;
        end
      endcase
    end
    // entry zero of any decode means see-through
    fg_clear_o = (fg_entry_o == 4'h0);
    bg_clear_o = bitmap_i || (bg_entry_o == 4'h0);
  end

endmodule : osd_colour_map
`default_nettype wire

// >>> osd_host_end.sv
// Purpose: host-side end: turns apb commands into byte port strobes
// Assumes: apb slave with zero wait states
// Notes:   one port access in flight; commands while busy are dropped
`include "osd_cfg.svh"
`default_nettype none
module osd_host_end
  import osd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  osd_port_if.host port,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  host_state_e state;
  byte_t last_rdata;
  logic pwdata_held;
  logic apb_wr;
  logic cmd_go;

  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign cmd_go = apb_wr && paddr_i == `HOST_REG_CMD && state == HOST_IDLE;

  //////////////////////////////////////////////////////////////////////////
  // command sequencer

  // the index write must precede data traffic; software orders that [R07]
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= HOST_IDLE;
      port.port_addr <= 8'h00;
      port.port_wdata <= 8'h00;
      port.port_wr <= 1'b0;
      port.port_rd <= 1'b0;
    end else begin
      port.port_wr <= 1'b0;
      port.port_rd <= 1'b0;
      case (state)
        HOST_IDLE: begin
          if (cmd_go) begin
            port.port_addr <= pwdata_i[`HOST_CMD_PORT_LSB +: 8];
            port.port_wdata <= pwdata_i[`HOST_CMD_DATA_LSB +: 8];
            state <= HOST_ISSUE;
          end
        end
        HOST_ISSUE: begin
          if (pwdata_held) begin
            port.port_wr <= 1'b1; // [R11] [R14] [R10]
            state <= HOST_IDLE;
          end else begin
            port.port_rd <= 1'b1;
            state <= HOST_WAIT;
          end
        end
        HOST_WAIT: begin
          if (port.port_rack) begin
            state <= HOST_IDLE;
          end
        end
        default: state <= HOST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwdata_held <= 1'b0;
    end else if (cmd_go) begin
      pwdata_held <= pwdata_i[`HOST_CMD_WRITE_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_rdata <= 8'h00;
    end else if (state == HOST_WAIT && port.port_rack) begin
      last_rdata <= port.port_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register read

  always_comb begin
    prdata_o = 32'h0000_0000;
    if (paddr_i == `HOST_REG_STATUS) begin
      prdata_o[`HOST_STAT_BUSY_BIT] = (state != HOST_IDLE);
      prdata_o[`HOST_STAT_RDATA_LSB +: 8] = last_rdata;
    end else if (paddr_i == `HOST_REG_CMD) begin
      prdata_o[`HOST_CMD_PORT_LSB +: 8] = port.port_addr;
      prdata_o[`HOST_CMD_DATA_LSB +: 8] = port.port_wdata;
      prdata_o[`HOST_CMD_WRITE_BIT] = pwdata_held;
    end
  end

endmodule : osd_host_end
`default_nettype wire

// >>> osd_host_ram_lut_access.sv
// Purpose: display-side end of the host port: config bank, colour table,
//          font/character ram loader and colour code decode
// Assumes: host strobes are one-cycle pulses on clk_i
// Notes:   ram contents are never returned to the host
`include "osd_cfg.svh"
`default_nettype none

// Operation
// R01: mode 0 foreground: zero clear, else entry
// R02: mode 0 background: zero clear, else even entry
// R03: mode 1: code one uses row attribute colours
// R04: mode 2: two-bit foreground, background via row
// R05: bitmap 1bpp: one selects entry one
// R06: bitmap 2bpp: values map to entries one-three
// R07: index port selects register behind data port
// R08: sixteen twelve-bit rgb colour table entries
// R09: table writable only while index selects it
// R10: other index ends table programming
// R11: two bytes per entry, then pointer advances
// R12: pointer wraps fifteen to zero
// R13: 1024 x 16 display ram, fonts from zero
// R14: pointer loaded through low and high ports
// R15: odd writes latch low byte, even store
// R16: host stores fonts row per word consecutively
// R17: narrow fonts drop low-order row bits
// R18: display ram reads return nothing
// R19: address port reads show live pointer
// R20: table pointer parks at one when deselected
// R21: address port write resets byte phase
module osd_host_ram_lut_access
  import osd_pkg::*;
#(
  parameter int RAM_WORDS = `OSD_RAM_WORDS,
  parameter int LUT_ENTRIES = `OSD_LUT_ENTRIES,
  parameter int CFG_COUNT = `OSD_CFG_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  osd_port_if.device port,
  // display pipeline side
  input wire logic [9:0] font_addr_i,
  output logic [15:0] font_row_o,
  input wire logic bitmap_i,
  input wire logic two_bpp_i,
  input wire logic [3:0] foreground_code_i,
  input wire logic [2:0] background_code_i,
  input wire logic [3:0] row_foreground_colour_i,
  input wire logic [2:0] row_background_colour_i,
  input wire logic [1:0] pixel_i,
  output logic [11:0] fg_rgb_o,
  output logic fg_clear_o,
  output logic [11:0] bg_rgb_o,
  output logic bg_clear_o
);

  // ram and table indices are fixed-width slices, so sizes cannot vary
  if (RAM_WORDS != 1024 || LUT_ENTRIES != 16 ||
      CFG_COUNT != 16) begin : g_bad_geometry
    $error("osd_host_ram_lut_access: unsupported geometry");
  end

  //////////////////////////////////////////////////////////////////////////
  // port decode

  function automatic logic hit(input logic [7:0] a, input logic [7:0] p);
    hit = (a == p);
  endfunction : hit

  logic wr_index;
  logic wr_data;
  logic wr_ptr_lo;
  logic wr_ptr_hi;
  logic wr_ram;
  logic lut_selected;

  assign wr_index = port.port_wr && hit(port.port_addr, `OSD_PORT_INDEX);
  assign wr_data = port.port_wr && hit(port.port_addr, `OSD_PORT_DATA);
  assign wr_ptr_lo = port.port_wr && hit(port.port_addr, `OSD_PORT_PTR_LO);
  assign wr_ptr_hi = port.port_wr && hit(port.port_addr, `OSD_PORT_PTR_HI);
  assign wr_ram = port.port_wr && hit(port.port_addr, `OSD_PORT_RAM_DATA);

  //////////////////////////////////////////////////////////////////////////
  // index and configuration bank

  byte_t cfg_index;
  byte_t cfg_bank [CFG_COUNT];

  assign lut_selected = (cfg_index == `OSD_LUT_DATA_INDEX);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_index <= `OSD_INDEX_RESET;
    end else if (wr_index) begin
      cfg_index <= port.port_wdata; // [R07]
    end
  end

  // only the low sixteen indices hold storage; the table port has none
  genvar gi;
  generate
    for (gi = 0; gi < CFG_COUNT; gi++) begin : g_cfg
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          cfg_bank[gi] <= `OSD_CFG_RESET;
        end else if (wr_data && cfg_index == 8'(gi) && !lut_selected) begin
          cfg_bank[gi] <= port.port_wdata; // [R07]
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // colour table

  rgb_t lut [LUT_ENTRIES];
  logic [3:0] lut_ptr;
  logic lut_phase;
  byte_t lut_green_blue;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lut_ptr <= `OSD_LUT_PTR_IDLE;
      lut_phase <= 1'b0;
      lut_green_blue <= 8'h00;
    end else if (!lut_selected) begin
      lut_ptr <= `OSD_LUT_PTR_IDLE; // [R20] [R10]
      lut_phase <= 1'b0;
    end else if (wr_data) begin // [R09]
      lut_phase <= !lut_phase;
      if (!lut_phase) begin
        lut_green_blue <= port.port_wdata; // [R11]
      end else begin
        lut_ptr <= lut_ptr + 4'h1; // [R11] [R12]
      end
    end
  end

  // red rides in the low nibble of the second byte; the upper is dropped
  always_ff @(posedge clk_i) begin
    if (lut_selected && wr_data && lut_phase) begin
      lut[lut_ptr] <= {port.port_wdata[3:0], lut_green_blue}; // [R08]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // display ram loader

  logic [15:0] ram [RAM_WORDS];
  logic [11:0] ram_ptr;
  logic ram_phase;
  byte_t ram_low;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_ptr <= `OSD_PTR_RESET;
      ram_phase <= 1'b0;
      ram_low <= 8'h00;
    end else if (wr_ptr_lo) begin
      ram_ptr[7:0] <= port.port_wdata; // [R14]
      ram_phase <= 1'b0; // [R21]
    end else if (wr_ptr_hi) begin
      ram_ptr[11:8] <= port.port_wdata[3:0]; // [R14]
      ram_phase <= 1'b0; // [R21]
    end else if (wr_ram) begin
      ram_phase <= !ram_phase;
      if (!ram_phase) begin
        ram_low <= port.port_wdata; // [R15]
      end else begin
        ram_ptr <= ram_ptr + 12'h001; // [R15]
      end
    end
  end

  // words beyond the ram fold onto it through the low pointer bits
  always_ff @(posedge clk_i) begin
    if (wr_ram && ram_phase && !wr_ptr_lo && !wr_ptr_hi) begin
      ram[ram_ptr[9:0]] <= {port.port_wdata, ram_low}; // [R13] [R15]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // host read path

  byte_t next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    case (port.port_addr)
      `OSD_PORT_INDEX: next_rdata = cfg_index;
      `OSD_PORT_DATA: begin
        if (!lut_selected && cfg_index < 8'(CFG_COUNT)) begin
          next_rdata = cfg_bank[cfg_index[3:0]]; // [R07]
        end
      end
      `OSD_PORT_PTR_LO: next_rdata = ram_ptr[7:0]; // [R19]
      `OSD_PORT_PTR_HI: next_rdata = {4'h0, ram_ptr[11:8]}; // [R19]
      `OSD_PORT_RAM_DATA: next_rdata = 8'h00; // [R18]
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port.port_rdata <= 8'h00;
      port.port_rack <= 1'b0;
    end else begin
      port.port_rack <= port.port_rd;
      if (port.port_rd) begin
        port.port_rdata <= next_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // font fetch for the display pipeline

  // fonts sit one row per word from address zero, by the host's layout
  logic [2:0] width_code;
  logic [15:0] width_mask;

  assign width_code = cfg_bank[`OSD_FONT_SIZE_INDEX][`OSD_FONT_WIDTH_LSB +: 3];

  // codes 3..7 give widths 6..14, anything else is a full 16-pixel row
  always_comb begin
    if (width_code >= 3'd3) begin
      width_mask = 16'hffff << (5'd16 - {1'b0, width_code, 1'b0}); // [R17]
    end else begin
      width_mask = 16'hffff;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      font_row_o <= 16'h0000;
    end else begin
      font_row_o <= ram[font_addr_i] & width_mask; // [R17] [R16]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // colour decode and table lookup

  logic [3:0] fg_entry;
  logic [3:0] bg_entry;
  logic fg_clear;
  logic bg_clear;

  osd_colour_map i_osd_colour_map (
    .coding_mode_i(cfg_bank[`OSD_CODING_INDEX][`OSD_CODING_MODE_LSB +: 2]),
    .bitmap_i(bitmap_i),
    .two_bpp_i(two_bpp_i),
    .foreground_code_i(foreground_code_i),
    .background_code_i(background_code_i),
    .row_foreground_colour_i(row_foreground_colour_i),
    .row_background_colour_i(row_background_colour_i),
    .pixel_i(pixel_i),
    .fg_entry_o(fg_entry),
    .fg_clear_o(fg_clear),
    .bg_entry_o(bg_entry),
    .bg_clear_o(bg_clear)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fg_rgb_o <= 12'h000;
      bg_rgb_o <= 12'h000;
      fg_clear_o <= 1'b1;
      bg_clear_o <= 1'b1;
    end else begin
      fg_rgb_o <= fg_clear ? 12'h000 : lut[fg_entry]; // [R01] [R05]
      bg_rgb_o <= bg_clear ? 12'h000 : lut[bg_entry]; // [R02]
      fg_clear_o <= fg_clear;
      bg_clear_o <= bg_clear;
    end
  end

endmodule : osd_host_ram_lut_access
`default_nettype wire

// >>> osd_link_checker.sv
// Purpose: port link checks between host end and display end
// Assumes: one clock, asynchronous active-low reset
// Notes: shadows the index and the ram pointer
`include "osd_cfg.svh"
`default_nettype none
module osd_link_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] port_addr,
  input wire logic [7:0] port_wdata,
  input wire logic port_wr,
  input wire logic port_rd,
  input wire logic [7:0] port_rdata,
  input wire logic port_rack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] ptr;
  logic phase;
  logic [7:0] index;
  wire logic [7:0] ptr_lo = ptr[7:0];
  wire logic [3:0] ptr_hi = ptr[11:8];
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
////////////////////////////////////////////////////////////////////
  // an address write restarts the byte phase, so the shadow does too
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr <= `OSD_PTR_RESET;
      phase <= 1'b0;
    end else if (port_wr && port_addr == `OSD_PORT_PTR_LO) begin
      ptr[7:0] <= port_wdata;
      phase <= 1'b0;
    end else if (port_wr && port_addr == `OSD_PORT_PTR_HI) begin
      ptr[11:8] <= port_wdata[3:0];
      phase <= 1'b0;
    end else if (port_wr && port_addr == `OSD_PORT_RAM_DATA) begin
      phase <= ~phase;
      ptr <= ptr + {11'h000, phase};
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      index <= `OSD_INDEX_RESET;
    end else if (port_wr && port_addr == `OSD_PORT_INDEX) begin
      index <= port_wdata;
    end
  end
  sequence s_rd(logic [7:0] p);
    port_rd && port_addr == p;
  endsequence
////////////////////////////////////////////////////////////////////
  a_rack_follows: assert property (port_rd |=> port_rack)
    else $error("read not acknowledged");
  a_rack_cause: assert property (!port_rd |=> !port_rack)
    else $error("acknowledge without read");
  a_rdata_held: assert property (!port_rack |-> $stable(port_rdata))
    else $error("read data moved");
  a_wr_single: assert property (port_wr |=> !port_wr)
    else $error("write strobe too long");
  a_one_strobe: assert property (!(port_wr && port_rd))
    else $error("read and write together");
  a_index_back: assert property (
    s_rd(`OSD_PORT_INDEX) |=> port_rdata == $past(index))
    else $error("index read back wrong");
  a_bank_hole: assert property (
    s_rd(`OSD_PORT_DATA) ##0 index > 8'h0f |=> port_rdata == 8'h00)
    else $error("hole in bank not zero");
  a_ram_unread: assert property (
    s_rd(`OSD_PORT_RAM_DATA) |=> port_rdata == 8'h00)
    else $error("ram data returned");
  a_ptr_low: assert property (
    s_rd(`OSD_PORT_PTR_LO) |=> port_rdata == $past(ptr_lo))
    else $error("pointer low byte wrong");
  a_ptr_high: assert property (
    s_rd(`OSD_PORT_PTR_HI) |=> port_rdata[3:0] == $past(ptr_hi))
    else $error("pointer high bits wrong");
endmodule : osd_link_checker
`default_nettype wire

// >>> osd_pkg.sv
// Purpose: shared types of the display host port
// Assumes: constants live in osd_cfg.svh
// Notes:   none
`default_nettype none
package osd_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [11:0] rgb_t;
  typedef enum logic [1:0] {MODE_FULL, MODE_ROW_ATTR, MODE_NARROW,
                            MODE_RESERVED} coding_mode_e;
  typedef enum {HOST_IDLE, HOST_ISSUE, HOST_WAIT} host_state_e;
endpackage : osd_pkg
`default_nettype wire

// >>> osd_port_if.sv
// Purpose: byte-wide i/o port between host controller and display device
// Assumes: single clock, strobes are one-cycle pulses
// Notes:   read data answers one cycle after the read strobe
`default_nettype none
interface osd_port_if;
  logic [7:0] port_addr;
  logic [7:0] port_wdata;
  logic port_wr;
  logic port_rd;
  logic [7:0] port_rdata;
  logic port_rack;

  modport device (input port_addr, input port_wdata, input port_wr,
                  input port_rd, output port_rdata, output port_rack);
  modport host (output port_addr, output port_wdata, output port_wr,
                output port_rd, input port_rdata, input port_rack);
endinterface : osd_port_if
`default_nettype wire

// >>> tb_osd_host_ram_lut_access.sv
// Purpose: end-to-end test of host end and display end over the link
// Assumes: apb software side, one clock
// Notes: table entry zero cannot be seen at the pixel outputs
`include "osd_cfg.svh"
`default_nettype none
module tb_osd_host_ram_lut_access import osd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] idx_p = `OSD_PORT_INDEX;
  localparam logic [7:0] dat_p = `OSD_PORT_DATA;
  localparam logic [7:0] plo_p = `OSD_PORT_PTR_LO;
  localparam logic [7:0] phi_p = `OSD_PORT_PTR_HI;
  localparam logic [7:0] ram_p = `OSD_PORT_RAM_DATA;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready;
  logic pslverr;
  logic [9:0] font_addr = 10'h000;
  logic [15:0] font_row;
  logic bitmap = 1'b0;
  logic two_bpp = 1'b0;
  logic [3:0] fg_code = 4'h0;
  logic [3:0] row_fg = 4'h0;
  logic [2:0] bg_code = 3'h0;
  logic [2:0] row_bg = 3'h0;
  logic [1:0] pixel = 2'h0;
  logic [11:0] fg_rgb;
  logic [11:0] bg_rgb;
  logic fg_clear;
  logic bg_clear;
  logic [11:0] lut [16];
  int err_count = 0;
  int check_count = 0;
  always #2 clk_i = ~clk_i;
  osd_port_if port ();
  osd_host_end i_osd_host_end (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .port(port), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr));
  osd_host_ram_lut_access i_osd_host_ram_lut_access (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .port(port), .font_addr_i(font_addr),
    .font_row_o(font_row), .bitmap_i(bitmap), .two_bpp_i(two_bpp),
    .foreground_code_i(fg_code), .background_code_i(bg_code),
    .row_foreground_colour_i(row_fg), .row_background_colour_i(row_bg),
    .pixel_i(pixel), .fg_rgb_o(fg_rgb), .fg_clear_o(fg_clear),
    .bg_rgb_o(bg_rgb), .bg_clear_o(bg_clear));
  osd_link_checker i_osd_link_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .port_addr(port.port_addr), .port_wdata(port.port_wdata),
    .port_wr(port.port_wr), .port_rd(port.port_rd),
    .port_rdata(port.port_rdata), .port_rack(port.port_rack));
////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  // idle edge at the end keeps back-to-back calls off one time step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    q = prdata;
    check({31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  // busy is polled since a command issued while busy is dropped
  task automatic io(input logic w, input logic [7:0] p, input logic [7:0] d);
    apb(1'b1, `HOST_REG_CMD, {15'h0, w, p, d});
    do apb(1'b0, `HOST_REG_STATUS, 32'h0); while (q[0] !== 1'b0);
  endtask : io
  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    io(1'b0, p, 8'h00);
    check({24'h0, q[15:8]}, {24'h0, exp});
  endtask : rd
  task automatic cfg(input logic [7:0] i, input logic [7:0] d);
    io(1'b1, idx_p, i);
    io(1'b1, dat_p, d);
  endtask : cfg
  task automatic font(input logic [9:0] a, input logic [15:0] exp);
    font_addr <= a;
    repeat (2) @(posedge clk_i);
    check({16'h0, font_row}, {16'h0, exp});
  endtask : font
  function automatic logic [31:0] col(input logic [4:0] e);
    return {19'h0, e[4], e[4] ? 12'h000 : lut[e[3:0]]};
  endfunction : col
  // bx packs bitmap, two bits per pixel and the pixel value
  task automatic pix(input logic [1:0] m, input logic [3:0] f,
                     input logic [2:0] b, input logic [3:0] rf,
                     input logic [2:0] rb, input logic [3:0] bx);
    logic [4:0] ef;
    logic [4:0] eb;
    fg_code <= f;
    bg_code <= b;
    row_fg <= rf;
    row_bg <= rb;
    {bitmap, two_bpp, pixel} <= bx;
    case (m)
      2'h0: ef = {f == 4'h0, f};
      2'h1: ef = f[0] ? {rf == 4'h0, rf} : 5'h10;
      2'h2: ef = {f[1:0] == 2'h0, 2'h0, f[1:0]};
      default: ef = 5'h10;
    endcase
    eb = (m == 2'h3 || !b[0]) ? 5'h10 : {rb == 3'h0, rb, 1'b0};
    if (m == 2'h0) begin
      eb = {b == 3'h0, b, 1'b0};
    end
    if (bx[3]) begin
      ef = bx[2] ? {bx[1:0] == 2'h0, 2'h0, bx[1:0]} : {!bx[0], 4'h1};
      eb = 5'h10;
    end
    repeat (2) @(posedge clk_i);
    check({19'h0, fg_clear, fg_rgb}, col(ef));
    check({19'h0, bg_clear, bg_rgb}, col(eb));
  endtask : pix
////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] c;
    logic [11:0] v;
    logic [15:0] mk;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(idx_p, `OSD_INDEX_RESET);
    rd(plo_p, 8'h00);
    rd(8'h55, 8'h00);
    cfg(8'h05, 8'h3e);
    cfg(8'h06, 8'hc1);
    cfg(8'h20, 8'h77);
    rd(dat_p, 8'h00);
    io(1'b1, idx_p, 8'h05);
    rd(dat_p, 8'h3e);
    io(1'b1, idx_p, 8'h06);
    rd(dat_p, 8'hc1);
    rd(idx_p, 8'h06);
    io(1'b1, idx_p, `OSD_LUT_DATA_INDEX);
    for (int k = 1; k <= 17; k++) begin
      c = k[3:0];
      v = {c ^ 4'h9, ~c, c ^ {k[4], 3'h5}};
      io(1'b1, dat_p, v[7:0]);
      io(1'b1, dat_p, {4'h0, v[11:8]});
      lut[c] = v;
    end
    cfg(8'h00, 8'h5a);
    rd(dat_p, 8'h5a);
    io(1'b1, dat_p, 8'h00);
    io(1'b1, idx_p, `OSD_LUT_DATA_INDEX);
    io(1'b1, dat_p, 8'h99);
    io(1'b1, idx_p, 8'h00);
    io(1'b1, idx_p, `OSD_LUT_DATA_INDEX);
    io(1'b1, dat_p, 8'h21);
    io(1'b1, dat_p, 8'h03);
    lut[1] = 12'h321;
    for (int m = 0; m < 4; m++) begin
      cfg(8'h0f, {4'h0, m[1:0], 2'h0});
      for (int i = 0; i < 16; i++) begin
        c = i[3:0];
        pix(m[1:0], c, c[2:0], ~c, c[3:1], 4'h0);
      end
    end
    cfg(8'h0f, 8'h00);
    for (int i = 0; i < 8; i++) begin
      c = i[3:0];
      pix(2'h0, 4'h5, 3'h3, 4'h0, 3'h0, {1'b1, c[2], c[2] & c[1], c[0]});
    end
    cfg(8'h0d, 8'h00);
    io(1'b1, plo_p, 8'hfe);
    io(1'b1, phi_p, 8'h03);
    io(1'b1, ram_p, 8'h5a);
    io(1'b1, ram_p, 8'ha5);
    io(1'b1, ram_p, 8'hc3);
    io(1'b1, ram_p, 8'h3c);
    rd(plo_p, 8'h00);
    io(1'b0, phi_p, 8'h00);
    check({28'h0, q[11:8]}, 32'h4);
    rd(ram_p, 8'h00);
    io(1'b1, plo_p, 8'hfc);
    io(1'b1, phi_p, 8'h00);
    io(1'b1, ram_p, 8'h11);
    io(1'b1, plo_p, 8'hfc);
    io(1'b1, ram_p, 8'hcd);
    io(1'b1, ram_p, 8'hab);
    apb(1'b0, `HOST_REG_CMD, 32'h0);
    check(q, 32'h0001_a4ab);
    rd(plo_p, 8'hfd);
    font(10'h3fe, 16'ha55a);
    font(10'h3ff, 16'h3cc3);
    for (int w = 0; w < 8; w++) begin
      mk = (w < 3) ? 16'hffff : 16'hffff << (16 - 2 * w);
      cfg(8'h0d, w[7:0]);
      font(10'h0fc, 16'habcd & mk);
    end
    summarize();
  end
  initial begin
    #40000;
    err_count++;
    summarize();
  end
endmodule : tb_osd_host_ram_lut_access
`default_nettype wire
